// ==== logic/ppm_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_cell #(
  parameter bit ADC_OK = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] pullSel,
  input wire logic [4:0] funcSel,
  input wire logic gpioOut,
  input wire logic [31:0] periphOut,
  input wire logic [31:0] periphDrive,
  output logic padOut,
  output logic padOeN,
  output logic pullUpEn,
  output logic pullDownEn,
  output logic adcConnect
);
  // converter selected and legal on this pin
  wire isAdc;
  // plain general-purpose mode
  wire isGpio;
  // routed peripheral wants the pad and may drive it
  wire funcDrives;
  wire next_drive;
  wire next_data;
  wire next_up;
  wire next_down;

  assign isAdc = ADC_OK && (funcSel == ppm_pkg::FUNC_ADC);
  assign isGpio = (funcSel == ppm_pkg::FUNC_GPIO);
  assign funcDrives = ppm_pkg::FUNC_CAN_DRIVE[funcSel] & periphDrive[funcSel];
  assign next_drive = !isAdc && (isGpio ? (pullSel == ppm_pkg::PULL_OUT) : funcDrives);
  assign next_data = next_drive && (isGpio ? gpioOut : periphOut[funcSel]);
  assign next_up = !isAdc && (pullSel == ppm_pkg::PULL_UP_IN);
  assign next_down = !isAdc && (pullSel == ppm_pkg::PULL_DOWN_IN);

  // pad controls come from flops; reset leaves an input with pull-down
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      padOut <= 1'b0;
      padOeN <= 1'b1;
      pullUpEn <= 1'b0;
      pullDownEn <= 1'b1;
      adcConnect <= 1'b0;
    end else begin
      padOut <= next_data;
      padOeN <= !next_drive;
      pullUpEn <= next_up;
      pullDownEn <= next_down;
      adcConnect <= isAdc;
    end
  end
endmodule
`default_nettype wire

// ==== logic/ppm_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_sync #(
  parameter int WIDTH = 10
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  // three-stage chain per bit
  logic [WIDTH-1:0] stageA;
  logic [WIDTH-1:0] stageB;
  logic [WIDTH-1:0] stageC;
  // a change is accepted only where the last two stages agree
  logic [WIDTH-1:0] agree;

  assign agree = ~(stageB ^ stageC);

  // stageA feeds stageB only, so metastability stays contained
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stageA <= '0;
      stageB <= '0;
      stageC <= '0;
    end else begin
      stageA <= asyncIn;
      stageB <= stageA;
      stageC <= stageB;
    end
  end

  // filtered value, costs one glitch-free cycle of latency
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      syncOut <= '0;
    end else begin
      syncOut <= (agree & stageC) | (~agree & syncOut);
    end
  end
endmodule
`default_nettype wire

// ==== logic/ppm_pkg.sv ====
package ppm_pkg;
  // pin count and function space
  localparam int NUM_PINS = 10;
  localparam int FUNC_COUNT = 32;
  localparam int REG_WIDTH = 16;

  // byte addresses of the ten pin mode registers
  localparam logic [31:0] PIN1_MODE_ADDR = 32'h5000_3008;
  localparam logic [31:0] PIN2_MODE_ADDR = 32'h5000_300a;
  localparam logic [31:0] PIN3_MODE_ADDR = 32'h5000_300c;
  localparam logic [31:0] PIN4_MODE_ADDR = 32'h5000_300e;
  localparam logic [31:0] PIN5_MODE_ADDR = 32'h5000_3010;
  localparam logic [31:0] PIN6_MODE_ADDR = 32'h5000_3012;
  localparam logic [31:0] PIN7_MODE_ADDR = 32'h5000_3014;
  localparam logic [31:0] PIN8_MODE_ADDR = 32'h5000_3016;
  localparam logic [31:0] PIN9_MODE_ADDR = 32'h5000_3018;
  localparam logic [31:0] PIN10_MODE_ADDR = 32'h5000_301a;
  // registers are halfwords, two bytes apart
  localparam int REG_STRIDE_SHIFT = 1;

  // field positions inside a mode register
  localparam int PULL_LSB = 8;
  localparam int PULL_MSB = 9;
  localparam int FUNC_LSB = 0;
  localparam int FUNC_MSB = 4;

  // reset values
  localparam logic [1:0] PULL_RESET = 2'h2;
  localparam logic [4:0] FUNC_RESET = 5'h00;

  // pull_direction_sel codes
  localparam logic [1:0] PULL_NONE_IN = 2'h0;
  localparam logic [1:0] PULL_UP_IN = 2'h1;
  localparam logic [1:0] PULL_DOWN_IN = 2'h2;
  localparam logic [1:0] PULL_OUT = 2'h3;

  // pin_function_sel codes with special handling
  localparam logic [4:0] FUNC_GPIO = 5'h00;
  localparam logic [4:0] FUNC_ADC = 5'h0f;

  // functions whose peripheral may drive the pad (outputs and two-way)
  localparam logic [31:0] FUNC_CAN_DRIVE = 32'h7b97_3e74;
  // functions whose peripheral reads the pad (inputs and two-way)
  localparam logic [31:0] FUNC_CAN_READ = 32'h7408_068a;
  // pins 1, 2, 6 and 7 carry a converter input (bit 0 is pin 1)
  localparam logic [9:0] ADC_PIN_MASK = 10'h063;
endpackage

// ==== logic/ppm_port_mode.sv ====
// Functional notes
// - code three drives output in gpio mode, no resistors
// - codes zero to two: input in gpio mode, pull choice
// - pull field resets to pull-down input
// - converter function ignores the pull field
// - ten halfword registers, pins one to ten
// - function zero is gpio, others route peripherals
// - shared input function fed by lowest pin
// - converter code works on four pins only
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mode #(
  parameter int NUM_PINS = ppm_pkg::NUM_PINS,
  parameter logic [31:0] FUNC_IN_IDLE = 32'h0000_0000
) (
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  // general-purpose data
  input wire logic [NUM_PINS-1:0] gpioOut,
  output logic [NUM_PINS-1:0] gpioIn,
  // peripheral side, one bit per function code
  input wire logic [31:0] periphOut,
  input wire logic [31:0] periphDrive,
  output logic [31:0] periphIn,
  // pad side
  input wire logic [NUM_PINS-1:0] padIn,
  output logic [NUM_PINS-1:0] padOut,
  output logic [NUM_PINS-1:0] padOeN,
  output logic [NUM_PINS-1:0] pullUpEn,
  output logic [NUM_PINS-1:0] pullDownEn,
  output logic [NUM_PINS-1:0] adcConnect
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------

  // only the live fields are stored; reserved bits have no flops
  logic [1:0] pullDir [NUM_PINS];
  logic [4:0] funcSel [NUM_PINS];

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------

  // offset of the access from the first pin register
  wire [31:0] addrOffset;
  // halfword index, pin one is index zero
  wire [3:0] regIndex;
  // access lands inside the block's range
  wire inRange;
  // halfword aligned
  wire aligned;
  // decoded hit on one of the mode registers
  wire regHit;
  // qualified strobes
  wire wrHit;
  wire rdHit;

  assign addrOffset = regAddr - ppm_pkg::PIN1_MODE_ADDR;
  assign regIndex = 4'(addrOffset >> ppm_pkg::REG_STRIDE_SHIFT);
  assign inRange = (regAddr >= ppm_pkg::PIN1_MODE_ADDR) && (regAddr <= ppm_pkg::PIN10_MODE_ADDR);
  // odd byte addresses fall between registers and are unmapped
  assign aligned = (regAddr[0] == 1'b0);
  assign regHit = inRange && aligned && (32'(regIndex) < NUM_PINS);
  assign wrHit = regWrEn && regHit;
  assign rdHit = regRdEn && regHit;

  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------

  // new field values from the bus word
  wire [1:0] wrPull;
  wire [4:0] wrFunc;

  assign wrPull = regWrData[ppm_pkg::PULL_MSB:ppm_pkg::PULL_LSB];
  assign wrFunc = regWrData[ppm_pkg::FUNC_MSB:ppm_pkg::FUNC_LSB];

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_reg
      // this pin's register is addressed
      wire sel;
      assign sel = wrHit && (regIndex == 4'(gp));

      // one mode register per pin, written whole
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          pullDir[gp] <= ppm_pkg::PULL_RESET;
          funcSel[gp] <= ppm_pkg::FUNC_RESET;
        end else if (sel) begin
          pullDir[gp] <= wrPull;
          funcSel[gp] <= wrFunc;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------

  // register image of the addressed pin
  logic [15:0] rdImage;
  // next value of the read data flop
  wire [15:0] next_rdData;

  // assemble the addressed register, reserved bits as zero
  always_comb begin
    rdImage = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (regIndex == 4'(i)) begin
        rdImage[ppm_pkg::PULL_MSB:ppm_pkg::PULL_LSB] = pullDir[i];
        rdImage[ppm_pkg::FUNC_MSB:ppm_pkg::FUNC_LSB] = funcSel[i];
      end
    end
  end

  // unmapped reads answer zero instead of stalling the master
  assign next_rdData = rdHit ? rdImage : 16'h0000;

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= next_rdData;
    end
  end

  // ------------------------------------------------------------
  // pad input synchroniser
  // ------------------------------------------------------------

  // pad levels, settled in the clock domain
  logic [NUM_PINS-1:0] padSync;

  // pads are asynchronous to the clock, so filter them first
  ppm_pin_sync #(
    .WIDTH(NUM_PINS)
  ) i_ppm_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .asyncIn(padIn),
    .syncOut(padSync)
  );

  // gpio read value is the settled pad level in every mode
  assign gpioIn = padSync;

  // ------------------------------------------------------------
  // per-pin pad control
  // ------------------------------------------------------------

  genvar gc;
  generate
    for (gc = 0; gc < NUM_PINS; gc++) begin : g_cell
      // converter switch only exists where the mask says so
      ppm_pin_cell #(
        .ADC_OK(ppm_pkg::ADC_PIN_MASK[gc])
      ) i_ppm_pin_cell (
        .clock(clock),
        .sys_rst(sys_rst),
        .pullSel(pullDir[gc]),
        .funcSel(funcSel[gc]),
        .gpioOut(gpioOut[gc]),
        .periphOut(periphOut),
        .periphDrive(periphDrive),
        .padOut(padOut[gc]),
        .padOeN(padOeN[gc]),
        .pullUpEn(pullUpEn[gc]),
        .pullDownEn(pullDownEn[gc]),
        .adcConnect(adcConnect[gc])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // peripheral input routing
  // ------------------------------------------------------------

  // value each input function would see this cycle
  logic [31:0] next_periphIn;

  genvar gf;
  generate
    for (gf = 0; gf < ppm_pkg::FUNC_COUNT; gf++) begin : g_func
      // walk from the top pin down so the lowest match is applied last
      always_comb begin
        next_periphIn[gf] = FUNC_IN_IDLE[gf];
        if (ppm_pkg::FUNC_CAN_READ[gf]) begin
          for (int p = NUM_PINS - 1; p >= 0; p--) begin
            if (funcSel[p] == 5'(gf)) begin
              next_periphIn[gf] = padSync[p];
            end
          end
        end
      end
    end
  endgenerate

  // registered so peripherals see a clean level, one cycle late
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      periphIn <= 32'h0000_0000;
    end else begin
      periphIn <= next_periphIn;
    end
  end

endmodule
`default_nettype wire

// ==== verification/ppm_port_mode_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches register port and pad controls of the mode block
module ppm_port_mode_monitor #(
  parameter int NUM_PINS = 10
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regRdData,
  input wire logic [NUM_PINS-1:0] padOeN,
  input wire logic [NUM_PINS-1:0] pullUpEn,
  input wire logic [NUM_PINS-1:0] pullDownEn,
  input wire logic [NUM_PINS-1:0] adcConnect
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // write to pin 1, pads follow two edges later
  wire logic pin1Wr = regWrEn && regAddr == ppm_pkg::PIN1_MODE_ADDR;
  // odd or outside the ten halfwords
  wire logic badAddr = regAddr[0] || regAddr < ppm_pkg::PIN1_MODE_ADDR || regAddr > ppm_pkg::PIN10_MODE_ADDR;
  property p_pull_out;
    pin1Wr && regWrData[9:0] == 10'h300 |-> ##2 !padOeN[0] && !pullUpEn[0] && !pullDownEn[0];
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pin 1 output mode wrong");
  property p_pull_in;
    pin1Wr && regWrData[4:0] == 5'h00 && regWrData[9:8] != 2'h3 |-> ##2
      padOeN[0] && pullUpEn[0] == $past(regWrData[8], 2) && pullDownEn[0] == $past(regWrData[9], 2);
  endproperty
  a_pull_in: assert property (p_pull_in) else $error("pin 1 input pull wrong");
  property p_reset_pull;
    $fell(sys_rst) |-> pullDownEn == {NUM_PINS{1'b1}} && padOeN == {NUM_PINS{1'b1}} && pullUpEn == '0;
  endproperty
  a_reset_pull: assert property (p_reset_pull) else $error("pads not pull-down inputs after reset");
  property p_adc_pin1;
    pin1Wr && regWrData[4:0] == ppm_pkg::FUNC_ADC |-> ##2
      adcConnect[0] && padOeN[0] && !pullUpEn[0] && !pullDownEn[0];
  endproperty
  a_adc_pin1: assert property (p_adc_pin1) else $error("converter mode not honoured");
  property p_read_window;
    !$past(regRdEn) |-> regRdData == 16'h0;
  endproperty
  a_read_window: assert property (p_read_window) else $error("read data outside window");
  property p_unmapped;
    regRdEn && badAddr |=> regRdData == 16'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_adc_pins;
    (adcConnect & ~ppm_pkg::ADC_PIN_MASK) == '0;
  endproperty
  a_adc_pins: assert property (p_adc_pins) else $error("converter on wrong pin");
  property p_reserved_zero;
    (regRdData & 16'hfce0) == 16'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
  // main scenarios reached
  c_read: cover property (regRdEn ##1 regRdData != 16'h0);
  c_adc: cover property (adcConnect[0]);
  c_drive: cover property (!padOeN[1]);
endmodule
bind ppm_port_mode ppm_port_mode_monitor #(.NUM_PINS(NUM_PINS)) i_ppm_port_mode_monitor (
  .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .padOeN(padOeN), .pullUpEn(pullUpEn),
  .pullDownEn(pullDownEn), .adcConnect(adcConnect));
`default_nettype wire

// ==== verification/ppm_port_mode_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// compare helper, counts every check
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module ppm_port_mode_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] regAddr = 32'h0;
  logic [15:0] regWrData = 16'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic [9:0] gpioOut = 10'h0;
  logic [31:0] periphOut = 32'h0;
  logic [31:0] periphDrive = 32'h0;
  logic [9:0] padIn = 10'h0;
  logic [31:0] periphIn;
  logic [9:0] gpioIn, padOut, padOeN, pullUpEn, pullDownEn, adcConnect;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  ppm_port_mode #(.NUM_PINS(10)) i_ppm_port_mode (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .gpioOut(gpioOut),
    .gpioIn(gpioIn), .periphOut(periphOut), .periphDrive(periphDrive), .periphIn(periphIn), .padIn(padIn),
    .padOut(padOut), .padOeN(padOeN), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .adcConnect(adcConnect));
  // 8 ns clock
  initial begin
    forever #4 clock = ~clock;
  end
  // hang guard, run needs under two hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  // halfword address of pin p
  function automatic logic [31:0] pa(input int p);
    return ppm_pkg::PIN1_MODE_ADDR + 32'(2 * (p - 1));
  endfunction
  // one write cycle, strobe held up to the sampling edge
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask
  // one read cycle, data only valid in the next cycle
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1;
    `CHK("regRdData", e, regRdData)
  endtask
  // reset held four cycles
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
  endtask
  // let registered pad outputs land
  task automatic wait_pads(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    for (int p = 1; p <= 10; p++) rd(pa(p), 16'h0200);
    `CHK("pullDownEn", 10'h3ff, pullDownEn)
    `CHK("padOeN", 10'h3ff, padOeN)
    // reserved bits set on write must vanish
    for (int p = 1; p <= 10; p++) wr(pa(p), 16'hfce0 | {6'h0, 2'(p % 4), 3'h0, 5'(p)});
    for (int p = 1; p <= 10; p++) rd(pa(p), {6'h0, 2'(p % 4), 3'h0, 5'(p)});
    // below, odd and above the map
    rd(32'h5000_3006, 16'h0);
    rd(32'h5000_3009, 16'h0);
    rd(32'h5000_301c, 16'h0);
    wr(32'h5000_3009, 16'h030f);
    rd(pa(1), 16'h0101);
    // second reset mid-run
    do_reset();
    rd(pa(4), 16'h0200);
    // every pull code on a gpio pin, inputs change on the edge
    @(posedge clock);
    gpioOut <= 10'h001;
    for (int c = 0; c < 4; c++) begin
      wr(pa(1), {6'h0, 2'(c), 8'h00});
      wait_pads(2);
      `CHK("pullUpEn0", c == 1, pullUpEn[0])
      `CHK("pullDownEn0", c == 2, pullDownEn[0])
      `CHK("padOeN0", c != 3, padOeN[0])
      `CHK("padOut0", c == 3, padOut[0])
    end
    // converter on a capable and an incapable pin, pull-up code ignored only on the first
    wr(pa(1), 16'h010f);
    wr(pa(3), 16'h010f);
    wait_pads(2);
    `CHK("adcConnect", 10'h001, adcConnect)
    `CHK("pullUpEn", 10'h004, pullUpEn)
    `CHK("pullDownEn", 10'h3fa, pullDownEn)
    `CHK("padOeN", 10'h3ff, padOeN)
    // peripheral drives pin 2, direction follows its request
    @(posedge clock);
    periphOut <= 32'h4;
    periphDrive <= 32'h4;
    wr(pa(2), 16'h0002);
    wait_pads(2);
    `CHK("padOeN1", 1'b0, padOeN[1])
    `CHK("padOut1", 1'b1, padOut[1])
    @(posedge clock);
    periphDrive <= 32'h0;
    wait_pads(2);
    `CHK("padOeN1", 1'b1, padOeN[1])
    // one input function on pins 4 and 6, lower pin wins
    wr(pa(4), 16'h0001);
    wr(pa(6), 16'h0001);
    @(posedge clock);
    padIn <= 10'h008;
    wait_pads(8);
    `CHK("periphIn1", 1'b1, periphIn[1])
    `CHK("gpioIn", 10'h008, gpioIn)
    @(posedge clock);
    padIn <= 10'h020;
    wait_pads(8);
    `CHK("periphIn1", 1'b0, periphIn[1])
    finish_test();
  end
endmodule
`undef CHK
`default_nettype wire
